// >>> core/ccb_jump.sv
// reset jump sequencer: feeds jump opcode and target bytes to the first three reads
module ccb_jump (
	input  wire logic mclk,
	input  wire logic sys_rst,
	ccb_jump_if.seq   jif
);
	ccb_pkg::ccb_jstate_t state_q;
	logic                 read_q;
	logic                 read_end;

	// a step advances when a read ends, so the byte holds for the whole access
	assign read_end = read_q & ~jif.mem_read;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_q <= 1'b0;
		end else begin
			read_q <= jif.mem_read;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= ccb_pkg::CCB_J_IDLE;
		end else if (jif.start) begin
			state_q <= ccb_pkg::CCB_J_OP;
		end else if (read_end) begin
			unique case (state_q)
				ccb_pkg::CCB_J_IDLE: state_q <= ccb_pkg::CCB_J_IDLE;
				ccb_pkg::CCB_J_OP:   state_q <= ccb_pkg::CCB_J_LO;
				ccb_pkg::CCB_J_LO:   state_q <= ccb_pkg::CCB_J_HI;
				ccb_pkg::CCB_J_HI:   state_q <= ccb_pkg::CCB_J_IDLE;
			endcase
		end
	end

	assign jif.active = (state_q != ccb_pkg::CCB_J_IDLE);

	always_comb begin
		unique case (state_q)
			ccb_pkg::CCB_J_OP: jif.byte_out = ccb_pkg::JUMP_OPCODE;
			ccb_pkg::CCB_J_LO: jif.byte_out = jif.vector[7:0];
			ccb_pkg::CCB_J_HI: jif.byte_out = jif.vector[15:8];
			default:           jif.byte_out = ccb_pkg::DATA_RESET;
		endcase
	end
endmodule : ccb_jump

// >>> core/ccb_jump_if.sv
// carrier between the glue core and the reset jump sequencer
interface ccb_jump_if;
	logic        start;        // reset seen, jump requested
	logic        mem_read;     // processor memory read in progress
	logic [15:0] vector;       // latched jump target
	logic        active;       // sequencer owns the data lines
	logic [7:0]  byte_out;     // byte forced onto the data lines

	modport seq  (input start, input mem_read, input vector, output active, output byte_out);
	modport core (output start, output mem_read, output vector, input active, input byte_out);
endinterface : ccb_jump_if

// >>> core/ccb_pkg.sv
// constants and types shared by the cpu card glue logic
package ccb_pkg;
	localparam int unsigned CLK_MHZ      = 125;          // mclk rate
	localparam int unsigned CPU_MHZ_SLOW = 2;            // switch low
	localparam int unsigned CPU_MHZ_FAST = 4;            // switch high
	// cycles of mclk per processor clock, rounded down
	localparam int unsigned DIV_SLOW     = CLK_MHZ / CPU_MHZ_SLOW;
	localparam int unsigned DIV_FAST     = CLK_MHZ / CPU_MHZ_FAST;
	localparam int unsigned DIV_W        = 7;
	localparam logic [15:0] ROM_BASE     = 16'hf000;     // on-board rom start
	localparam logic [15:0] ROM_MASK     = 16'hf000;     // bits decoding the rom
	localparam logic [15:0] RESET_ADDR   = 16'h0000;     // fetch start with no jump
	localparam logic [15:0] NMI_ADDR     = 16'h0066;     // processor nmi restart
	localparam logic [7:0]  JUMP_OPCODE  = 8'hc3;        // absolute jump opcode
	localparam logic [7:0]  DATA_RESET   = 8'h00;

	// forced jump sequence steps
	typedef enum logic [1:0] {
		CCB_J_IDLE = 2'b00,
		CCB_J_OP   = 2'b01,
		CCB_J_LO   = 2'b10,
		CCB_J_HI   = 2'b11
	} ccb_jstate_t;
endpackage : ccb_pkg

// >>> core/ccb_top.sv
// cpu card glue: reset jump, rom overlay, speed status and gated bus lines
//
// How it works
// - jump enabled: first fetch after reset goes to jumper vector address.
// - jump disabled: processor starts fetching at address zero.
// - jumper bits form the target, highest jumper is the top bit.
// - on-board rom answers from F000h; vector F000h starts the rom.
// - stack status line high at 4 MHz, low at 2 MHz.
// - speed indicator line undriven when its enable is off.
// - phantom with overlay enabled deselects the rom for that access.
// - phantom input can be ignored through its enable.
// - maskable interrupt passed only while processor interrupt-enable is set.
// - nonmaskable interrupt restarts at 0066h regardless of interrupt-enable.
// - bus nmi has no effect when its enable is off.
// - refresh address and refresh strobe follow each opcode fetch.
// - refresh strobe reaches the bus only when enabled.
// - clock speed selectable 2/4 MHz, fixed at reset.
// - memory request strobe presented on bus as fitted option.
module ccb_top #(
	parameter int unsigned ADDR_W = 16
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// card settings (jumpers and switch)
	input  wire logic              reset_jump_enable,
	input  wire logic [ADDR_W-1:0] vector_jumper_bits,
	input  wire logic              speed_switch_fast,
	input  wire logic              speed_line_enable,
	input  wire logic              phantom_enable,
	input  wire logic              nmi_enable,
	input  wire logic              refresh_enable,
	input  wire logic              memory_request_strobe_fitted,
	// processor side
	input  wire logic [ADDR_W-1:0] cpu_addr,
	input  wire logic              cpu_memory_request_strobe,
	input  wire logic              cpu_read,
	input  wire logic              cpu_opcode_fetch_cycle,
	input  wire logic              cpu_refresh,
	input  wire logic              cpu_int_enable_ff,
	output logic [7:0]             cpu_data,
	output logic                   cpu_int_req,
	output logic                   cpu_nmi_req,
	output logic                   cpu_clk_en,
	// on-board rom
	input  wire logic [7:0]        rom_data,
	output logic                   rom_select,
	// backplane side
	input  wire logic [7:0]        bus_data_in,
	input  wire logic              bus_phantom,
	input  wire logic              bus_int_req,
	input  wire logic              bus_nmi,
	output logic [ADDR_W-1:0]      bus_addr,
	output logic                   bus_mem_read,
	output logic                   bus_refresh_out,
	output logic                   bus_refresh_oe,
	output logic                   stack_status_line_out,
	output logic                   stack_status_line_oe,
	output logic                   bus_memory_request_strobe_out,
	output logic                   bus_memory_request_strobe_oe
);
	logic                         speed_fast_q;
	logic                         jump_en_q;
	logic [ADDR_W-1:0]            vector_q;
	logic                         start_q;
	logic [ccb_pkg::DIV_W-1:0]    div_q;
	logic [ccb_pkg::DIV_W-1:0]    div_top;
	logic                         mem_read;
	logic                         rom_hit;
	logic                         overlay;

	ccb_jump_if jif ();

	////////////////////////////////////////////////////////////////////////////
	// settings latched during reset

	// one latched switch copy feeds both clock and indicator
	// switch changes after reset are ignored until the next reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			speed_fast_q <= speed_switch_fast;
			jump_en_q    <= reset_jump_enable;
			vector_q     <= vector_jumper_bits;
		end
	end

	// start flag set during reset, held for one cycle after reset release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			start_q <= 1'b1;
		end else begin
			start_q <= 1'b0;
		end
	end

	// start the jump only when enabled
	// with no jump the processor runs its own reset fetch from zero
	assign jif.start    = start_q & jump_en_q;
	// jumper word taken as binary, bit ADDR_W-1 highest
	assign jif.vector   = vector_q;
	assign mem_read     = cpu_memory_request_strobe & cpu_read & ~cpu_refresh;
	assign jif.mem_read = mem_read;

	ccb_jump ccb_jump_inst (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.jif     (jif)
	);

	////////////////////////////////////////////////////////////////////////////
	// processor clock enable

	// divider count chosen by the latched switch
	assign div_top = speed_fast_q ? ccb_pkg::DIV_W'(ccb_pkg::DIV_FAST - 1)
	                              : ccb_pkg::DIV_W'(ccb_pkg::DIV_SLOW - 1);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_q      <= '0;
			cpu_clk_en <= 1'b0;
		end else if (div_q >= div_top) begin
			div_q      <= '0;
			cpu_clk_en <= 1'b1;
		end else begin
			div_q      <= div_q + 1'b1;
			cpu_clk_en <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// rom decode and data steering

	// rom window at the top 4k
	assign rom_hit = ((cpu_addr & ccb_pkg::ROM_MASK) == ccb_pkg::ROM_BASE);
	// phantom takes the byte away from the rom
	assign overlay = phantom_enable & bus_phantom;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rom_select   <= 1'b0;
			bus_mem_read <= 1'b0;
		end else begin
			rom_select   <= mem_read & rom_hit & ~overlay & ~jif.active;
			// backplane read suppressed while the jump bytes are forced
			bus_mem_read <= mem_read & ~jif.active & ~(rom_hit & ~overlay);
		end
	end

	// forced bytes override memory; released once the sequence ends
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cpu_data <= ccb_pkg::DATA_RESET;
		end else if (jif.active) begin
			cpu_data <= jif.byte_out;
		end else if (rom_hit & ~overlay) begin
			cpu_data <= rom_data;
		end else begin
			cpu_data <= bus_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	// maskable request gated by processor interrupt-enable
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cpu_int_req <= 1'b0;
		end else begin
			cpu_int_req <= bus_int_req & cpu_int_enable_ff;
		end
	end

	// bus nmi gated by its enable only
	// never masked by interrupt-enable; processor restarts at NMI_ADDR
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cpu_nmi_req <= 1'b0;
		end else begin
			cpu_nmi_req <= bus_nmi & nmi_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus address and gated control lines

	// refresh address passes on the address lines after each fetch
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_addr <= '0;
		end else begin
			bus_addr <= cpu_addr;
		end
	end

	// refresh strobe driven only when enabled
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_refresh_out <= 1'b0;
			bus_refresh_oe  <= 1'b0;
		end else begin
			bus_refresh_out <= cpu_refresh & ~cpu_opcode_fetch_cycle;
			bus_refresh_oe  <= refresh_enable;
		end
	end

	// high at 4 MHz from the latched switch
	// line released when disabled, avoids clash with error input use
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stack_status_line_out <= 1'b0;
			stack_status_line_oe  <= 1'b0;
		end else begin
			stack_status_line_out <= speed_fast_q;
			stack_status_line_oe  <= speed_line_enable;
		end
	end

	// memory request strobe onto the bus when fitted
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_memory_request_strobe_out <= 1'b0;
			bus_memory_request_strobe_oe  <= 1'b0;
		end else begin
			bus_memory_request_strobe_out <= cpu_memory_request_strobe;
			bus_memory_request_strobe_oe  <= memory_request_strobe_fitted;
		end
	end
endmodule : ccb_top

// >>> verif/ccb_backplane.sv
// backplane memory and phantom overlay board model
module ccb_backplane (
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_mem_read,
	input  wire logic        overlay_on,
	output logic [7:0]       bus_data_in,
	output logic             bus_phantom
);
	timeunit 1ns;
	timeprecision 1ns;
	// overlay board claims the rom window
	assign bus_phantom = overlay_on && bus_addr[15:12] == 4'hf;
	// released lines show the inverse byte so stale data never matches
	assign bus_data_in = (bus_addr[7:0] ^ 8'h5a) ^ {8{!bus_mem_read}};
endmodule : ccb_backplane

// >>> verif/ccb_top_asserts.sv
// assertion checker on the cpu card glue ports
module ccb_top_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic speed_line_enable,
	input wire logic phantom_enable,
	input wire logic nmi_enable,
	input wire logic refresh_enable,
	input wire logic cpu_opcode_fetch_cycle,
	input wire logic cpu_refresh,
	input wire logic cpu_int_enable_ff,
	input wire logic bus_phantom,
	input wire logic bus_int_req,
	input wire logic bus_nmi,
	input wire logic cpu_int_req,
	input wire logic cpu_nmi_req,
	input wire logic cpu_clk_en,
	input wire logic rom_select,
	input wire logic bus_refresh_oe,
	input wire logic bus_refresh_out,
	input wire logic stack_status_line_out,
	input wire logic stack_status_line_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// one domain, so one clock and one reset guard for all
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	//////////////////////////////
	chk_int_gate: assert property (cpu_int_req |-> $past(bus_int_req && cpu_int_enable_ff))
		else $error("int passed masked");
	chk_nmi_pass: assert property (bus_nmi && nmi_enable |=> cpu_nmi_req)
		else $error("nmi lost");
	chk_nmi_block: assert property (!nmi_enable |=> !cpu_nmi_req) else $error("nmi not gated");
	chk_rfsh_pass: assert property (cpu_refresh && !cpu_opcode_fetch_cycle |=> bus_refresh_out)
		else $error("refresh lost");
	chk_rfsh_mask: assert property (cpu_opcode_fetch_cycle |=> !bus_refresh_out)
		else $error("refresh during fetch");
	chk_rfsh_gate: assert property (!$past(sys_rst) |-> bus_refresh_oe == $past(refresh_enable))
		else $error("refresh enable wrong");
	chk_speed_gate: assert property (stack_status_line_oe |-> $past(speed_line_enable))
		else $error("speed line driven");
	// two quiet cycles first: the latched speed lands one edge after release
	chk_speed_hold: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(stack_status_line_out))
		else $error("speed status moved");
	chk_clk_period: assert property (cpu_clk_en |=> !cpu_clk_en [*8] ##[23:54] cpu_clk_en)
		else $error("clock pulse spacing");
	chk_phantom_rom: assert property (bus_phantom && phantom_enable |=> !rom_select)
		else $error("rom kept under phantom");
	cover property (bus_phantom && phantom_enable);
	cover property (cpu_nmi_req && !cpu_int_enable_ff);
	cover property (bus_refresh_out && bus_refresh_oe);
endmodule : ccb_top_asserts

// >>> verif/ccb_top_tb.sv
// self-checking bench for the cpu card glue
module ccb_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, sys_rst, reset_jump_enable, speed_switch_fast, speed_line_enable, phantom_enable;
	logic        nmi_enable, refresh_enable, memory_request_strobe_fitted, cpu_memory_request_strobe;
	logic        cpu_read, cpu_refresh;
	logic        cpu_opcode_fetch_cycle, cpu_int_enable_ff, bus_int_req, bus_nmi, bus_phantom, overlay_on;
	logic        cpu_int_req, cpu_nmi_req, cpu_clk_en, rom_select, bus_mem_read, bus_refresh_out, bus_refresh_oe;
	logic        stack_status_line_out, stack_status_line_oe;
	logic        bus_memory_request_strobe_out, bus_memory_request_strobe_oe;
	logic [15:0] vector_jumper_bits, cpu_addr, bus_addr;
	logic [7:0]  rom_data, bus_data_in, cpu_data;
	logic [15:0] vt [2] = '{16'hf000, 16'h1234};
	int          n_errors = 0;
	int          checks_done = 0;
	// design and backplane partner
	ccb_top ccb_top_inst (
		.mclk(mclk), .sys_rst(sys_rst), .reset_jump_enable(reset_jump_enable),
		.vector_jumper_bits(vector_jumper_bits), .speed_switch_fast(speed_switch_fast),
		.speed_line_enable(speed_line_enable), .phantom_enable(phantom_enable), .nmi_enable(nmi_enable),
		.refresh_enable(refresh_enable), .memory_request_strobe_fitted(memory_request_strobe_fitted),
		.cpu_addr(cpu_addr), .cpu_memory_request_strobe(cpu_memory_request_strobe), .cpu_read(cpu_read),
		.cpu_opcode_fetch_cycle(cpu_opcode_fetch_cycle), .cpu_refresh(cpu_refresh),
		.cpu_int_enable_ff(cpu_int_enable_ff), .cpu_data(cpu_data), .cpu_int_req(cpu_int_req),
		.cpu_nmi_req(cpu_nmi_req), .cpu_clk_en(cpu_clk_en), .rom_data(rom_data), .rom_select(rom_select),
		.bus_data_in(bus_data_in), .bus_phantom(bus_phantom), .bus_int_req(bus_int_req), .bus_nmi(bus_nmi),
		.bus_addr(bus_addr), .bus_mem_read(bus_mem_read), .bus_refresh_out(bus_refresh_out),
		.bus_refresh_oe(bus_refresh_oe), .stack_status_line_out(stack_status_line_out),
		.stack_status_line_oe(stack_status_line_oe),
		.bus_memory_request_strobe_out(bus_memory_request_strobe_out),
		.bus_memory_request_strobe_oe(bus_memory_request_strobe_oe)
	);
	ccb_backplane ccb_backplane_inst (
		.bus_addr(bus_addr), .bus_mem_read(bus_mem_read), .overlay_on(overlay_on),
		.bus_data_in(bus_data_in), .bus_phantom(bus_phantom)
	);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	//////////////////////////////
	// compare, memory read, reset with straps, clock period, gated levels
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic s);
		{cpu_addr, cpu_memory_request_strobe, cpu_read} = {a, 2'b11};
		repeat (4) @(negedge mclk);
		chk({8'h00, cpu_data}, {8'h00, e});
		chk(16'(rom_select), 16'(s));
		chk(bus_addr, a);
		{cpu_memory_request_strobe, cpu_read} = 2'b00;
		repeat (2) @(negedge mclk);
	endtask : rd
	task automatic rst(input logic j, input logic [15:0] v, input logic f);
		{sys_rst, reset_jump_enable, vector_jumper_bits, speed_switch_fast} = {1'b1, j, v, f};
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (2) @(negedge mclk);
	endtask : rst
	task automatic period(input int e);
		time t;
		@(posedge cpu_clk_en);
		t = $time;
		@(posedge cpu_clk_en);
		chk(16'(($time - t) / 8), 16'(e));
		@(negedge mclk);
	endtask : period
	task automatic gate(input logic [8:0] v, input logic [6:0] e);
		{bus_int_req, cpu_int_enable_ff, bus_nmi, nmi_enable, cpu_refresh, refresh_enable,
			cpu_memory_request_strobe, memory_request_strobe_fitted, speed_line_enable} = v;
		repeat (2) @(negedge mclk);
		chk({9'h000, cpu_int_req, cpu_nmi_req, bus_refresh_out, bus_refresh_oe, bus_memory_request_strobe_out,
			bus_memory_request_strobe_oe, stack_status_line_oe}, {9'h000, e});
	endtask : gate
	task automatic conclude;
		$display("errors %0d of %0d checks", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		{cpu_memory_request_strobe, cpu_read, cpu_refresh, cpu_opcode_fetch_cycle, cpu_int_enable_ff} = 5'h00;
		{bus_int_req, bus_nmi, overlay_on, memory_request_strobe_fitted, refresh_enable} = 5'h00;
		{speed_line_enable, phantom_enable, nmi_enable} = 3'h7;
		{cpu_addr, rom_data} = {16'h0000, 8'ha5};
		for (int i = 0; i < 2; i++) begin
			rst(1'b1, vt[i], i[0]);
			rd(16'h0000, ccb_pkg::JUMP_OPCODE, 1'b0);
			rd(16'h0001, vt[i][7:0], 1'b0);
			rd(16'h0002, vt[i][15:8], 1'b0);
			chk(16'(stack_status_line_out), 16'(i[0]));
			period(i[0] ? ccb_pkg::DIV_FAST : ccb_pkg::DIV_SLOW);
		end
		// a strap moved in mid-run must not reach the status line
		speed_switch_fast = 1'b0;
		repeat (4) @(negedge mclk);
		chk(16'(stack_status_line_out), 16'h0001);
		rd(ccb_pkg::ROM_BASE, rom_data, 1'b1);
		overlay_on = 1'b1;
		rd(16'hf003, 8'h59, 1'b0);
		phantom_enable = 1'b0;
		rd(16'hf003, rom_data, 1'b1);
		overlay_on = 1'b0;
		rst(1'b0, 16'hf000, 1'b0);
		rd(ccb_pkg::RESET_ADDR, 8'h5a, 1'b0);
		gate(9'b101000001, 7'b0000001);
		gate(9'b110011001, 7'b1011001);
		// refresh strobe held off while an opcode fetch is flagged
		cpu_opcode_fetch_cycle = 1'b1;
		gate(9'b110011001, 7'b1001001);
		cpu_opcode_fetch_cycle = 1'b0;
		gate(9'b001110111, 7'b0110111);
		gate(9'b000000100, 7'b0000100);
		conclude;
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#40000;
		n_errors++;
		conclude;
	end
endmodule : ccb_top_tb
// checker attached to every instance of the glue top
bind ccb_top ccb_top_asserts ccb_top_asserts_inst (
	.mclk(mclk), .sys_rst(sys_rst), .speed_line_enable(speed_line_enable), .phantom_enable(phantom_enable),
	.nmi_enable(nmi_enable), .refresh_enable(refresh_enable), .cpu_opcode_fetch_cycle(cpu_opcode_fetch_cycle),
	.cpu_refresh(cpu_refresh), .cpu_int_enable_ff(cpu_int_enable_ff), .bus_phantom(bus_phantom),
	.bus_int_req(bus_int_req), .bus_nmi(bus_nmi), .cpu_int_req(cpu_int_req), .cpu_nmi_req(cpu_nmi_req),
	.cpu_clk_en(cpu_clk_en), .rom_select(rom_select), .bus_refresh_oe(bus_refresh_oe),
	.bus_refresh_out(bus_refresh_out), .stack_status_line_out(stack_status_line_out),
	.stack_status_line_oe(stack_status_line_oe)
);
